/* bench/tb_top.sv */
// self-checking testbench for the watchdog register block
`timescale 1ns/100ps
`default_nettype none
`include "wtrf_consts.vh"
module tb_top;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic cclk = 1'b0; // count clock, unrelated phase
  wire logic psel, penable, pwrite, irq, rst_req;
  wire logic [3:0] paddr;
  wire logic [31:0] pwdata, prdata;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int ticks = 0;
  int rst_cyc = 0; // cycle of the last reset request
  int t0, e0, n;
  logic [31:0] seed = 32'h9E691265;
  logic [31:0] q, tc;
  always #4 mclk = ~mclk;
  always #14 cclk = ~cclk;
  always @(posedge mclk) cyc <= cyc + 1;
  always @(posedge cclk) ticks <= ticks + 1;
  always @(posedge mclk) if (rst_req === 1'b1) rst_cyc <= cyc;
  wtrf_wdt dut (.MCLK(mclk), .RESETN(resetn), .CE(1'b1), .COUNT_CLOCK(cclk), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .WDT_IRQ(irq), .WDT_RST_REQ(rst_req));
  wtrf_cpu_model cpu (.clk(mclk), .prdata(prdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // stored constant after the floor
  function automatic logic [31:0] tc_kept(input logic [31:0] v);
    return (v < `WTRF_TC_MIN) ? `WTRF_TC_MIN : v;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    cpu.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(`WTRF_OFF_MODE, 32'h0);
    rd_chk(`WTRF_OFF_TC, `WTRF_TC_RESET);
    rd_chk(`WTRF_OFF_SNAP, 32'hFF);
    rd_chk(`WTRF_OFF_FEED, 32'h0);
    rd_chk(4'h6, 32'h0);
    // constant floor at boundaries and at random
    for (int i = 0; i < 6; i++) begin
      cpu.idle = int'(rnd() & 32'h1);
      tc = (i == 0) ? 32'h0 : (i == 1) ? 32'hFE : (i == 2) ? 32'h100 : rnd() >> (8 * (i - 2));
      wr(`WTRF_OFF_TC, tc);
      rd_chk(`WTRF_OFF_TC, tc_kept(tc));
    end
    // run enable set only; errors before the first feed ignored
    wr(`WTRF_OFF_MODE, 32'h1);
    wr(`WTRF_OFF_FEED, 32'hAA);
    rd_chk(`WTRF_OFF_MODE, 32'h1);
    wr(`WTRF_OFF_MODE, 32'h0);
    rd_chk(`WTRF_OFF_MODE, 32'h1);
    chk({irq, 31'h0} | rst_cyc, 32'h0);
    // interrupt mode time-out
    tc = 32'h200 + (rnd() & 32'hFF);
    wr(`WTRF_OFF_TC, tc);
    cpu.feed();
    t0 = ticks;
    for (n = 0; n < 300 && ticks < t0 + 40; n++) @(posedge mclk);
    if (n >= 300) begin
      error_cnt++;
      results();
    end
    cpu.xfer(1'b0, `WTRF_OFF_SNAP, 32'h0, q);
    chk(q >= tc - 32'hB && q <= tc - 32'h5, 1'b1);
    for (n = 0; n < 20000 && irq !== 1'b1; n++) @(posedge mclk);
    if (n >= 20000) begin
      error_cnt++;
      results();
    end
    n = ticks - t0;
    chk(n >= (tc + 1) * 4 && n <= (tc + 1) * 4 + 8, 1'b1);
    chk(rst_cyc, 0);
    rd_chk(`WTRF_OFF_MODE, 32'hC);
    wr(`WTRF_OFF_MODE, 32'h0);
    rd_chk(`WTRF_OFF_MODE, 32'h8);
    chk(irq, 1'b1);
    // reset mode, then a wrong access inside a feed
    wr(`WTRF_OFF_MODE, 32'h3);
    rd_chk(`WTRF_OFF_MODE, 32'hB);
    cpu.feed();
    repeat (60) @(posedge mclk);
    wr(`WTRF_OFF_FEED, 32'hAA);
    cpu.xfer(1'b0, `WTRF_OFF_TC, 32'h0, q);
    e0 = cyc;
    repeat (4) @(posedge mclk);
    chk(rst_cyc, e0 + 2);
    rd_chk(`WTRF_OFF_MODE, 32'h4);
    chk(irq, 1'b0);
    // external reset after the watchdog reset clears the time-out flag
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(`WTRF_OFF_MODE, 32'h0);
    results();
  end
endmodule // tb_top
`default_nettype wire

/* bench/wtrf_cpu_model.sv */
// processor model driving the watchdog register bus
`timescale 1ns/100ps
`default_nettype none
`include "wtrf_consts.vh"
module wtrf_cpu_model (
  input wire logic clk,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [3:0] paddr,
  output logic [31:0] pwdata
);
  int idle = 0; // idle cycles before each transfer
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 4'h0;
    pwdata = 32'h0;
  end
  // setup edge, access edge, then release
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    repeat (idle) @(posedge clk);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic feed();
    logic [31:0] q;
    xfer(1'b1, `WTRF_OFF_FEED, {24'h0, `WTRF_KEY_FIRST}, q);
    xfer(1'b1, `WTRF_OFF_FEED, {24'h0, `WTRF_KEY_SECOND}, q);
  endtask
endmodule // wtrf_cpu_model
`default_nettype wire

/* bench/wtrf_wdt_properties.sv */
// assertion checker for the watchdog register block
`timescale 1ns/100ps
`default_nettype none
module wtrf_wdt_props #(
  parameter CW = 32
) (
  input wire MCLK,
  input wire RESETN,
  input wire CE,
  input wire COUNT_CLOCK,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [3:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire WDT_IRQ,
  input wire WDT_RST_REQ
);
  // read setup phase on the register bus
  wire rd_setup = PSEL && !PENABLE && !PWRITE;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);
  a_reset_quiet_out: assert property ($rose(RESETN) |-> !WDT_IRQ && !WDT_RST_REQ)
    else $error("outputs active right after reset");
  a_rst_single_pulse: assert property (WDT_RST_REQ |=> !WDT_RST_REQ [*4])
    else $error("chip reset request not a lone pulse");
  a_irq_held: assert property ($fell(WDT_IRQ) |->
    WDT_RST_REQ || $past(WDT_RST_REQ) || $past(WDT_RST_REQ, 2))
    else $error("interrupt request dropped without watchdog reset");
  a_irq_not_rst: assert property ($rose(WDT_IRQ) |-> !WDT_RST_REQ && !$past(WDT_RST_REQ))
    else $error("interrupt raised together with reset");
  a_feed_reads_zero: assert property (rd_setup && PADDR == 4'h8 |=> PRDATA == 32'h0)
    else $error("feed key readable");
  a_unmapped_zero: assert property (rd_setup && PADDR[1:0] != 2'h0 |=> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_mode_top_zero: assert property (rd_setup && PADDR == 4'h0 |=> PRDATA[31:4] == 28'h0)
    else $error("mode upper bits not zero");
  a_tc_floor: assert property (rd_setup && PADDR == 4'h4 |=> PRDATA >= 32'hFF)
    else $error("constant below floor");
  a_rdata_holds: assert property (!rd_setup |=> $stable(PRDATA))
    else $error("read data changed without read");
  a_irq_flag_seen: assert property (rd_setup && PADDR == 4'h0 && WDT_IRQ &&
    !WDT_RST_REQ |=> PRDATA[3])
    else $error("interrupt request without flag");
  c_irq: cover property ($rose(WDT_IRQ));
  c_rst: cover property ($rose(WDT_RST_REQ));
  c_feed: cover property (PSEL && PENABLE && PWRITE && PADDR == 4'h8 && PWDATA[7:0] == 8'h55);
endmodule // wtrf_wdt_props
bind wtrf_wdt wtrf_wdt_props #(.CW(CW)) u_props (.MCLK(MCLK), .RESETN(RESETN), .CE(CE),
  .COUNT_CLOCK(COUNT_CLOCK), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .WDT_IRQ(WDT_IRQ),
  .WDT_RST_REQ(WDT_RST_REQ));
`default_nettype wire

/* design/wtrf_dly.v */
// settle pipeline advancing once per count-clock tick
`timescale 1ns/100ps
`default_nettype none
module wtrf_dly #(
  parameter W = 35,
  parameter DEPTH = 3,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire clr,
  input wire shift,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] stage_reg [0:DEPTH-1]; // pipeline stages
  integer i;

  // shift on tick; synchronous clear for the watchdog's own reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        stage_reg[i] <= INIT;
      end
    end else if (ce) begin
      if (clr) begin
        for (i = 0; i < DEPTH; i = i + 1) begin
          stage_reg[i] <= INIT;
        end
      end else if (shift) begin
        stage_reg[0] <= din;
        for (i = 1; i < DEPTH; i = i + 1) begin
          stage_reg[i] <= stage_reg[i-1];
        end
      end
    end
  end

  // oldest stage drives the counter logic
  assign dout = stage_reg[DEPTH-1];
endmodule // wtrf_dly
`default_nettype wire

/* design/wtrf_sync.v */
// two-flop synchroniser with rising-edge tick for the count clock
`timescale 1ns/100ps
`default_nettype none
module wtrf_sync (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire async_in,
  output wire tick
);
  reg meta_reg; // first stage, read only by sync_reg
  reg sync_reg; // second stage
  reg prev_reg; // delayed copy for edge detection

  // sample and shift, frozen while clock enable is low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else if (ce) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // one pulse per rising count-clock edge
  assign tick = sync_reg & ~prev_reg;
endmodule // wtrf_sync
`default_nettype wire

/* design/wtrf_wdt.v */
// watchdog timer with mode, constant, feed and snapshot registers
`timescale 1ns/100ps
`default_nettype none
`include "wtrf_consts.vh"
module wtrf_wdt #(
  parameter CW = 32
) (
  input wire MCLK,
  input wire RESETN,
  input wire CE,
  input wire COUNT_CLOCK,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [3:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg WDT_IRQ,
  output reg WDT_RST_REQ
);
  // width of the settle pipeline word: constant, two mode bits, reload request
  localparam PW = CW + 3;

  // software-visible mode bits
  reg run_sw_reg; // set-only run enable
  reg rst_sw_reg; // set-only reset enable
  reg tof_reg; // time-out flag
  reg irq_reg; // interrupt flag, read only
  // mode copies made at a valid feed
  reg run_act_reg;
  reg rst_act_reg;
  // time-out constant
  reg [31:0] tc_reg;
  // feed sequence state
  reg feed_state_reg;
  // reload request waiting to enter the settle pipeline
  reg pend_reg;
  // watchdog has seen its first valid feed with run enabled
  reg started_reg;
  // counter, prescaler and snapshot
  reg [CW-1:0] count_reg;
  reg [1:0] presc_reg;
  reg [CW-1:0] snap_reg;
  // feed-error action waiting one clock
  reg err_pend_reg;

  // bus decode
  wire acc; // access phase of any transfer
  wire wr; // write access phase
  wire rd_setup; // setup phase of a read
  wire wr_mode;
  wire wr_tc;
  wire wr_feed;
  wire hit; // address maps to a watchdog register
  wire [7:0] feed_byte;

  // count-clock side
  wire tick; // one pulse per synchronised rising count-clock edge
  wire [PW-1:0] dly_in;
  wire [PW-1:0] dly_out;
  wire [CW-1:0] set_tc; // settled constant
  wire set_run; // settled run enable
  wire set_rst; // settled reset enable
  wire set_pend; // settled reload request
  wire running;
  wire ptick; // prescaled tick
  wire underflow;

  // event decode
  wire feed_ok; // 0x55 completes an armed sequence
  wire feed_err; // wrong access while armed
  wire fire; // time-out or feed error
  wire own_reset; // watchdog resets the chip
  wire own_irq; // watchdog raises the interrupt flag

  // floor a written constant at the minimum
  function [31:0] wtrf_floor;
    input [31:0] v;
    begin
      if (v < `WTRF_TC_MIN) begin
        wtrf_floor = `WTRF_TC_MIN;
      end else begin
        wtrf_floor = v;
      end
    end
  endfunction

  // compare a transfer address with a register offset
  function wtrf_at;
    input [3:0] a;
    input [3:0] off;
    begin
      wtrf_at = (a == off);
    end
  endfunction

  // bus phase decode
  assign acc = PSEL & PENABLE;
  assign wr = acc & PWRITE;
  assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
  assign wr_mode = wr & wtrf_at(PADDR, `WTRF_OFF_MODE);
  assign wr_tc = wr & wtrf_at(PADDR, `WTRF_OFF_TC);
  assign wr_feed = wr & wtrf_at(PADDR, `WTRF_OFF_FEED);
  assign hit = wtrf_at(PADDR, `WTRF_OFF_MODE) | wtrf_at(PADDR, `WTRF_OFF_TC) |
               wtrf_at(PADDR, `WTRF_OFF_FEED) | wtrf_at(PADDR, `WTRF_OFF_SNAP);
  assign feed_byte = PWDATA[7:0];

  assign feed_ok = wr_feed & (feed_state_reg == `WTRF_FEED_ARMED) &
                   (feed_byte == `WTRF_KEY_SECOND);
  // wrong access after the first key
  assign feed_err = acc & hit & (feed_state_reg == `WTRF_FEED_ARMED) & ~feed_ok &
                    started_reg;

  // synchronise the count clock into the bus clock
  wtrf_sync u_sync (
    .clk(MCLK),
    .rst_n(RESETN),
    .ce(CE),
    .async_in(COUNT_CLOCK),
    .tick(tick)
  );

  assign dly_in = {pend_reg, rst_act_reg, run_act_reg, tc_reg[CW-1:0]};
  wtrf_dly #(
    .W(PW),
    .DEPTH(`WTRF_SETTLE_DEPTH),
    .INIT({3'b000, `WTRF_TC_RESET})
  ) u_dly (
    .clk(MCLK),
    .rst_n(RESETN),
    .ce(CE),
    .clr(own_reset),
    .shift(tick),
    .din(dly_in),
    .dout(dly_out)
  );
  assign set_tc = dly_out[CW-1:0];
  assign set_run = dly_out[CW];
  assign set_rst = dly_out[CW+1];
  assign set_pend = dly_out[CW+2];

  // counting needs run enable and a first feed
  assign running = started_reg & set_run;
  assign ptick = tick & running & (presc_reg == `WTRF_PRESC_LAST);
  assign underflow = ptick & ~set_pend & (count_reg == {CW{1'b0}});

  // fires whenever running, independent of sleep
  assign fire = underflow | err_pend_reg;
  assign own_reset = fire & set_rst;
  assign own_irq = fire & ~set_rst;

  // feed sequence tracker
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      feed_state_reg <= `WTRF_FEED_IDLE;
    end else if (CE) begin
      if (own_reset) begin
        // watchdog reset drops a half-done sequence
        feed_state_reg <= `WTRF_FEED_IDLE;
      end else if (acc & hit) begin
        case (feed_state_reg)
          `WTRF_FEED_IDLE: begin
            if (wr_feed & (feed_byte == `WTRF_KEY_FIRST)) begin
              feed_state_reg <= `WTRF_FEED_ARMED;
            end
          end
          `WTRF_FEED_ARMED: begin
            // any mapped register access ends the sequence, good or bad
            feed_state_reg <= `WTRF_FEED_IDLE;
          end
          default: begin
            feed_state_reg <= `WTRF_FEED_IDLE;
          end
        endcase
      end
    end
  end

  // feed error held one clock so its action lands in the second clock
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      err_pend_reg <= 1'b0;
    end else if (CE) begin
      err_pend_reg <= feed_err & ~own_reset;
    end
  end

  // mode register bits
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      run_sw_reg <= 1'b0;
      rst_sw_reg <= 1'b0;
      run_act_reg <= 1'b0;
      rst_act_reg <= 1'b0;
    end else if (CE) begin
      if (fire) begin
        // underflow or feed error clears the enables
        run_sw_reg <= 1'b0;
        rst_sw_reg <= 1'b0;
        run_act_reg <= 1'b0;
        rst_act_reg <= 1'b0;
      end else begin
        if (wr_mode) begin
          run_sw_reg <= run_sw_reg | PWDATA[`WTRF_BIT_RUN];
          rst_sw_reg <= rst_sw_reg | PWDATA[`WTRF_BIT_RST];
        end
        if (feed_ok) begin
          run_act_reg <= run_sw_reg;
          rst_act_reg <= rst_sw_reg;
        end
      end
    end
  end

  // time-out flag: survives the watchdog's own reset
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      tof_reg <= 1'b0;
    end else if (CE) begin
      if (fire) begin
        // set wins over a software clear
        tof_reg <= 1'b1;
      end else if (wr_mode & ~PWDATA[`WTRF_BIT_TOF]) begin
        tof_reg <= 1'b0;
      end
    end
  end

  // interrupt flag: no software clear
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_reg <= 1'b0;
    end else if (CE) begin
      if (own_reset) begin
        irq_reg <= 1'b0;
      end else if (own_irq) begin
        irq_reg <= 1'b1;
      end
    end
  end

  // time-out constant register
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      tc_reg <= `WTRF_TC_RESET;
    end else if (CE) begin
      if (own_reset) begin
        tc_reg <= `WTRF_TC_RESET;
      end else if (wr_tc) begin
        tc_reg <= wtrf_floor(PWDATA);
      end
    end
  end

  // reload request waiting for the next tick
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      pend_reg <= 1'b0;
    end else if (CE) begin
      if (own_reset) begin
        pend_reg <= 1'b0;
      end else if (feed_ok) begin
        pend_reg <= 1'b1;
      end else if (tick) begin
        // request has moved into the pipeline
        pend_reg <= 1'b0;
      end
    end
  end

  // counter, prescaler and start flag
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      count_reg <= `WTRF_TC_RESET;
      presc_reg <= `WTRF_PRESC_ZERO;
      started_reg <= 1'b0;
    end else if (CE) begin
      if (fire) begin
        // stop counting until fed again
        started_reg <= 1'b0;
        presc_reg <= `WTRF_PRESC_ZERO;
        if (own_reset) begin
          count_reg <= `WTRF_TC_RESET;
        end
      end else if (tick & set_pend) begin
        count_reg <= set_tc;
        presc_reg <= `WTRF_PRESC_ZERO;
        started_reg <= set_run;
      end else if (tick & running) begin
        presc_reg <= presc_reg + 2'h1;
        if (ptick) begin
          count_reg <= count_reg - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // snapshot locked on each count tick
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      snap_reg <= `WTRF_TC_RESET;
    end else if (CE) begin
      if (tick) begin
        snap_reg <= count_reg;
      end
    end
  end

  // read data captured in the setup phase
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= `WTRF_ZERO32;
    end else if (CE) begin
      if (rd_setup) begin
        case (PADDR)
          `WTRF_OFF_MODE: begin
            PRDATA <= {28'h0000000, irq_reg, tof_reg, rst_sw_reg, run_sw_reg};
          end
          `WTRF_OFF_TC: begin
            PRDATA <= tc_reg;
          end
          `WTRF_OFF_SNAP: begin
            PRDATA <= snap_reg;
          end
          default: begin
            // feed register and unmapped addresses read zero
            PRDATA <= `WTRF_ZERO32;
          end
        endcase
      end
    end
  end

  // interrupt and chip reset outputs
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      WDT_IRQ <= 1'b0;
      WDT_RST_REQ <= 1'b0;
    end else if (CE) begin
      WDT_IRQ <= irq_reg & ~own_reset;
      // reset pulse in the second clock
      WDT_RST_REQ <= own_reset;
    end
  end
endmodule // wtrf_wdt
`default_nettype wire

/* inc/wtrf_consts.vh */
// constants shared by the watchdog timer design files
// Behaviour
// - mode bit 0 run enable, set only
// - mode bit 1 reset enable, set only
// - enables cleared only by reset, underflow or feed error
// - bit 2 timeout flag, survives own reset
// - bit 3 interrupt flag, read only
// - interrupt request held while flag set
// - mode writes act only after feed
// - run off stops; interrupt mode flags only
// - reset mode resets chip, no interrupt
// - constant resets 0xFF, floor 0xFF
// - feed reloads counter from constant
// - first feed starts; earlier errors ignored
// - wrong access after 0xAA triggers action
// - error reset in second clock after
// - counter read is a locked snapshot
// - fires whenever running, also asleep
// - divide-by-4 prescaler, underflow times out
// - settings reach counter 3 ticks later
`ifndef WTRF_CONSTS_VH
`define WTRF_CONSTS_VH
// register offsets
`define WTRF_OFF_MODE 4'h0
`define WTRF_OFF_TC 4'h4
`define WTRF_OFF_FEED 4'h8
`define WTRF_OFF_SNAP 4'hC
// mode register bit positions
`define WTRF_BIT_RUN 0
`define WTRF_BIT_RST 1
`define WTRF_BIT_TOF 2
`define WTRF_BIT_IRQ 3
// reset values and limits
`define WTRF_TC_RESET 32'h000000FF
`define WTRF_TC_MIN 32'h000000FF
`define WTRF_ZERO32 32'h00000000
// feed keys
`define WTRF_KEY_FIRST 8'hAA
`define WTRF_KEY_SECOND 8'h55
// prescaler terminal value (divide by 4)
`define WTRF_PRESC_LAST 2'h3
`define WTRF_PRESC_ZERO 2'h0
// depth of the settle pipeline in count-clock ticks
`define WTRF_SETTLE_DEPTH 3
// feed sequence states
`define WTRF_FEED_IDLE 1'b0
`define WTRF_FEED_ARMED 1'b1
`endif
